// >>> design/reset_strap_clock_ratio_config.sv
// Overview of operation
// [R1] capture the four platform ratio straps at power-up to set platform clock
// [R2] decode platform ratio codes; reserved codes flagged as not valid
// [R3] board must drive every platform ratio strap; no default exists
// [R4] capture core ratio straps msb first and decode; 001 and 010 reserved
// [R5] board picks platform ratio so platform clock equals memory data rate
// [R6] memory bus clock runs at half the platform clock
// [R7] board keeps memory bus clock between 166 and 266 MHz
// [R8] board keeps platform clock at or above 333 MHz
// [R9] board keeps core clock between 667 MHz and speed-grade maximum
// [R10] outside 33-66 MHz reference, board supplies an asynchronous pci clock
// [R11] weak pull-ups on configuration inputs enabled only while in reset; here held on after release until the straps are captured
// [R12] serdes reference-clock select strap defaults low when undriven
// [R13] spare straps sampled but unused; board should allow pulling them low
// [R14] internal arbiter strap makes pci address pins driven despite block disable
// [R15] strap values latched once at reset end, held until next reset
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module reset_strap_clock_ratio_config (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // strap pins
    input wire logic [3:0] I_BUS_RATIO_STRAPS,
    input wire logic I_CORE_RATIO_STRAP_MSB,
    input wire logic I_CORE_RATIO_STRAP_MID,
    input wire logic I_CORE_RATIO_STRAP_LSB,
    input wire logic I_SRDS_REFCLK_SEL_STRAP,
    input wire logic I_PCI_ARB_STRAP,
    input wire logic [3:0] I_SPARE_STRAPS,
    // register port
    input wire logic [3:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // pad control
    output logic O_CFG_PULLUP_EN,
    output logic O_SRDS_PULLUP_EN,
    output logic O_PCI_ADDR_OE,
    // decoded clock configuration
    output logic [4:0] O_PLAT_MULT,
    output logic O_PLAT_RATIO_OK,
    output logic [3:0] O_CORE_HALVES,
    output logic O_CORE_RATIO_OK,
    output logic [4:0] O_MEM_HALVES,
    output logic O_SRDS_REFCLK_SEL,
    output logic O_CFG_DONE
);
    strap_cap_if cap_bus ();

    strap_capture u_capture (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_bus_ratio_straps(I_BUS_RATIO_STRAPS),
        .i_core_ratio_strap_msb(I_CORE_RATIO_STRAP_MSB),
        .i_core_ratio_strap_mid(I_CORE_RATIO_STRAP_MID),
        .i_core_ratio_strap_lsb(I_CORE_RATIO_STRAP_LSB),
        .i_srds_refclk_sel_strap(I_SRDS_REFCLK_SEL_STRAP),
        .i_pci_arb_strap(I_PCI_ARB_STRAP),
        .i_spare_straps(I_SPARE_STRAPS),
        .cap(cap_bus.cap)
    );

    strap_cfg_pkg::bus_ratio_type bus_dec;
    strap_cfg_pkg::core_ratio_type core_dec;

    // decoded ratio state
    logic [4:0] plat_mult_r;
    logic [4:0] plat_mult_nxt;
    logic plat_ok_r;
    logic plat_ok_nxt;
    logic [3:0] core_halves_r;
    logic [3:0] core_halves_nxt;
    logic core_ok_r;
    logic core_ok_nxt;
    logic [4:0] mem_halves_r;
    logic [4:0] mem_halves_nxt;
    logic srds_sel_r;
    logic srds_sel_nxt;
    logic done_r;
    logic done_nxt;

    // pad control state
    logic pullup_r;
    logic pullup_nxt;
    logic srds_pullup_r;
    logic srds_pullup_nxt;
    logic pci_oe_r;
    logic pci_oe_nxt;

    // register state
    logic [31:0] bdis_r;
    logic [31:0] bdis_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    assign bus_dec = strap_cfg_pkg::decode_bus(cap_bus.bus_code); // [R2]
    assign core_dec = strap_cfg_pkg::decode_core(cap_bus.core_code); // [R4]

    // decoding of the held straps into clock ratios
    always_comb begin
        plat_mult_nxt = plat_mult_r;
        plat_ok_nxt = plat_ok_r;
        core_halves_nxt = core_halves_r;
        core_ok_nxt = core_ok_r;
        mem_halves_nxt = mem_halves_r;
        srds_sel_nxt = srds_sel_r;
        done_nxt = cap_bus.done;
        if (cap_bus.done) begin
            plat_mult_nxt = bus_dec.mult; // [R1]
            plat_ok_nxt = bus_dec.ok; // [R2]
            core_halves_nxt = core_dec.halves; // [R4]
            core_ok_nxt = core_dec.ok; // [R4]
            // memory clock to reference ratio in halves equals platform multiplier
            mem_halves_nxt = bus_dec.mult; // [R6]
            srds_sel_nxt = cap_bus.srds_sel; // [R12]
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            plat_mult_r <= 5'h00;
            plat_ok_r <= 1'b0;
            core_halves_r <= 4'h0;
            core_ok_r <= 1'b0;
            mem_halves_r <= 5'h00;
            srds_sel_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            plat_mult_r <= plat_mult_nxt;
            plat_ok_r <= plat_ok_nxt;
            core_halves_r <= core_halves_nxt;
            core_ok_r <= core_ok_nxt;
            mem_halves_r <= mem_halves_nxt;
            srds_sel_r <= srds_sel_nxt;
            done_r <= done_nxt;
        end
    end

    // pad control: pull-ups from reset until the straps are captured, pci address drive
    always_comb begin
        pullup_nxt = !cap_bus.done; // [R11]
        srds_pullup_nxt = 1'b0; // [R12]
        pci_oe_nxt = 1'b0;
        if (cap_bus.done) begin
            pci_oe_nxt = cap_bus.pci_arb_int
                         || !bdis_r[strap_cfg_pkg::BDIS_PCI_POS]; // [R14]
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pullup_r <= 1'b1; // [R11]
            srds_pullup_r <= 1'b0; // [R12]
            pci_oe_r <= 1'b0;
        end else begin
            pullup_r <= pullup_nxt;
            srds_pullup_r <= srds_pullup_nxt;
            pci_oe_r <= pci_oe_nxt;
        end
    end

    // register port: writes and registered read data
    always_comb begin
        bdis_nxt = bdis_r;
        rdata_nxt = 32'h0000_0000;
        if (I_WR && I_ADDR == strap_cfg_pkg::OFS_BLOCK_DISABLE) begin
            bdis_nxt = 32'h0000_0000;
            bdis_nxt[strap_cfg_pkg::BDIS_PCI_POS] = I_WDATA[strap_cfg_pkg::BDIS_PCI_POS];
        end
        if (I_RD) begin
            unique case (I_ADDR)
                strap_cfg_pkg::OFS_STRAP_RAW: begin
                    rdata_nxt[strap_cfg_pkg::RAW_BUS_POS +: 4] = cap_bus.bus_code;
                    rdata_nxt[strap_cfg_pkg::RAW_CORE_POS +: 3] = cap_bus.core_code;
                    rdata_nxt[strap_cfg_pkg::RAW_SRDS_POS] = cap_bus.srds_sel;
                    rdata_nxt[strap_cfg_pkg::RAW_ARB_POS] = cap_bus.pci_arb_int;
                    // spare straps are only reported, never used
                    rdata_nxt[strap_cfg_pkg::RAW_SPARE_POS +: 4] = cap_bus.spare; // [R13]
                end
                strap_cfg_pkg::OFS_RATIO: begin
                    rdata_nxt[strap_cfg_pkg::RATIO_BUS_POS +: 5] = plat_mult_r;
                    rdata_nxt[strap_cfg_pkg::RATIO_CORE_POS +: 4] = core_halves_r;
                    rdata_nxt[strap_cfg_pkg::RATIO_MEM_POS +: 5] = mem_halves_r;
                end
                strap_cfg_pkg::OFS_BLOCK_DISABLE: begin
                    rdata_nxt = bdis_r;
                end
                strap_cfg_pkg::OFS_CFG_STATUS: begin
                    rdata_nxt[strap_cfg_pkg::STAT_DONE_POS] = done_r;
                    rdata_nxt[strap_cfg_pkg::STAT_BUS_OK_POS] = plat_ok_r;
                    rdata_nxt[strap_cfg_pkg::STAT_CORE_OK_POS] = core_ok_r;
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            bdis_r <= strap_cfg_pkg::BLOCK_DISABLE_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            bdis_r <= bdis_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign O_RDATA = rdata_r;
    assign O_CFG_PULLUP_EN = pullup_r;
    assign O_SRDS_PULLUP_EN = srds_pullup_r;
    assign O_PCI_ADDR_OE = pci_oe_r;
    assign O_PLAT_MULT = plat_mult_r;
    assign O_PLAT_RATIO_OK = plat_ok_r;
    assign O_CORE_HALVES = core_halves_r;
    assign O_CORE_RATIO_OK = core_ok_r;
    assign O_MEM_HALVES = mem_halves_r;
    assign O_SRDS_REFCLK_SEL = srds_sel_r;
    assign O_CFG_DONE = done_r;
endmodule
`default_nettype wire

// >>> design/strap_capture.sv
`timescale 1ns/10ps
`default_nettype none
module strap_capture (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // strap pins
    input wire logic [3:0] i_bus_ratio_straps,
    input wire logic i_core_ratio_strap_msb,
    input wire logic i_core_ratio_strap_mid,
    input wire logic i_core_ratio_strap_lsb,
    input wire logic i_srds_refclk_sel_strap,
    input wire logic i_pci_arb_strap,
    input wire logic [3:0] i_spare_straps,
    // captured values
    strap_cap_if.cap cap
);
    logic [12:0] pins;
    logic [12:0] sync1_r;
    logic [12:0] sync2_r;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    logic [12:0] held_r;
    logic [12:0] held_nxt;
    logic done_r;
    logic done_nxt;

    assign pins = {i_spare_straps, i_pci_arb_strap, i_srds_refclk_sel_strap,
                   i_core_ratio_strap_msb, i_core_ratio_strap_mid,
                   i_core_ratio_strap_lsb, i_bus_ratio_straps};

    // two-stage synchroniser for the strap pins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_r <= 13'h0000;
            sync2_r <= 13'h0000;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    // take the straps once after release, then hold them
    always_comb begin
        settle_nxt = settle_r;
        held_nxt = held_r;
        done_nxt = done_r;
        if (!done_r) begin
            if (settle_r == strap_cfg_pkg::SETTLE_CYCLES) begin
                held_nxt = sync2_r; // [R1] [R4] [R15]
                done_nxt = 1'b1;
            end else begin
                settle_nxt = settle_r + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            settle_r <= 2'h0;
            held_r <= 13'h0000;
            done_r <= 1'b0;
        end else begin
            settle_r <= settle_nxt;
            held_r <= held_nxt;
            done_r <= done_nxt;
        end
    end

    assign cap.bus_code = held_r[3:0];
    assign cap.core_code = held_r[6:4];
    assign cap.srds_sel = held_r[7];
    assign cap.pci_arb_int = held_r[8];
    assign cap.spare = held_r[12:9];
    assign cap.done = done_r;
endmodule
`default_nettype wire

// >>> dv/reset_strap_clock_ratio_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %s", $time, m); end end
module reset_strap_clock_ratio_config_tb;
    logic I_CLK = 1'b0, I_RST_B = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
    logic [3:0] I_ADDR = 4'h0;
    logic [31:0] I_WDATA = 32'h0, O_RDATA, d;
    logic [3:0] bus = 4'h0, pbus, pspare, O_CORE_HALVES;
    logic [2:0] core = 3'h0, pcore;
    logic sdrv = 1'b0, sval = 1'b0, arb = 1'b0, wig = 1'b0, psrds, parb;
    logic O_CFG_PULLUP_EN, O_SRDS_PULLUP_EN, O_PCI_ADDR_OE, O_PLAT_RATIO_OK;
    logic O_CORE_RATIO_OK, O_SRDS_REFCLK_SEL, O_CFG_DONE;
    logic [4:0] O_PLAT_MULT, O_MEM_HALVES;
    logic [4:0] pm [16] = '{5'h10, 5'h00, 5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
                            5'h08, 5'h09, 5'h0A, 5'h00, 5'h0C, 5'h00, 5'h00, 5'h00};
    logic [3:0] ch [8] = '{4'h8, 4'h0, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    int error_cnt = 0, n_checks = 0;
    always #20 I_CLK = ~I_CLK;
    strap_board i_strap_board (.i_bus(bus), .i_core(core), .i_srds_drv(sdrv),
        .i_srds_val(sval), .i_arb(arb), .i_wiggle(wig), .o_bus(pbus), .o_core(pcore),
        .o_srds(psrds), .o_arb(parb), .o_spare(pspare));
    reset_strap_clock_ratio_config i_reset_strap_clock_ratio_config (.I_CLK(I_CLK),
        .I_RST_B(I_RST_B), .I_BUS_RATIO_STRAPS(pbus), .I_CORE_RATIO_STRAP_MSB(pcore[2]),
        .I_CORE_RATIO_STRAP_MID(pcore[1]), .I_CORE_RATIO_STRAP_LSB(pcore[0]),
        .I_SRDS_REFCLK_SEL_STRAP(psrds), .I_PCI_ARB_STRAP(parb), .I_SPARE_STRAPS(pspare),
        .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
        .O_CFG_PULLUP_EN(O_CFG_PULLUP_EN), .O_SRDS_PULLUP_EN(O_SRDS_PULLUP_EN),
        .O_PCI_ADDR_OE(O_PCI_ADDR_OE), .O_PLAT_MULT(O_PLAT_MULT),
        .O_PLAT_RATIO_OK(O_PLAT_RATIO_OK), .O_CORE_HALVES(O_CORE_HALVES),
        .O_CORE_RATIO_OK(O_CORE_RATIO_OK), .O_MEM_HALVES(O_MEM_HALVES),
        .O_SRDS_REFCLK_SEL(O_SRDS_REFCLK_SEL), .O_CFG_DONE(O_CFG_DONE));
    task close_out;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task rd(input logic [3:0] a);
        @(posedge I_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1 d = O_RDATA;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge I_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= v;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    task do_reset(input logic [3:0] b, input logic [2:0] c, input logic sd, sv, ar);
        int k;
        @(posedge I_CLK);
        I_RST_B <= 1'b0;
        wig <= 1'b0;
        {bus, core, sdrv, sval, arb} <= {b, c, sd, sv, ar};
        repeat (2) @(posedge I_CLK);
        #1 `CHK({O_CFG_PULLUP_EN, O_SRDS_PULLUP_EN, O_CFG_DONE}, 3'b100, "reset pull-up")
        @(posedge I_CLK);
        I_RST_B <= 1'b1;
        for (k = 0; k < 10 && O_CFG_DONE !== 1'b1; k++) @(posedge I_CLK);
        if (k == 10) begin
            error_cnt++;
            close_out();
        end
        repeat (2) @(posedge I_CLK);
    endtask
    task chk_cfg(input logic [3:0] b, input logic [2:0] c, input logic s, ar);
        `CHK(O_PLAT_MULT, pm[b], "platform ratio")
        `CHK(O_PLAT_RATIO_OK, pm[b] != 5'h00, "platform ok")
        `CHK(O_MEM_HALVES, pm[b], "memory ratio")
        `CHK(O_CORE_HALVES, ch[c], "core ratio")
        `CHK(O_CORE_RATIO_OK, ch[c] != 4'h0, "core ok")
        `CHK(O_SRDS_REFCLK_SEL, s, "serdes select")
        `CHK(O_SRDS_PULLUP_EN, 1'b0, "serdes pull-up")
        `CHK(O_CFG_PULLUP_EN, 1'b0, "pull-up after reset")
        rd(strap_cfg_pkg::OFS_STRAP_RAW);
        `CHK(d, {19'h0, 4'h0, ar, s, c, b}, "raw straps")
        rd(strap_cfg_pkg::OFS_CFG_STATUS);
        `CHK(d, {29'h0, ch[c] != 4'h0, pm[b] != 5'h00, 1'b1}, "status")
    endtask
    initial begin
        for (int i = 0; i < 16; i++) begin
            do_reset(i[3:0], i[2:0], i[0], i[1], i[2]);
            chk_cfg(i[3:0], i[2:0], i[0] & i[1], i[2]);
        end
        // pins move after capture: nothing may follow them
        // legal board setting on a 50 MHz reference: platform 450, memory 225, core 675
        do_reset(4'h9, 3'h3, 1'b1, 1'b1, 1'b0);
        wig <= 1'b1;
        repeat (6) @(posedge I_CLK);
        chk_cfg(4'h9, 3'h3, 1'b1, 1'b0);
        rd(4'hF);
        `CHK(d, 32'h0, "unmapped read")
        wr(strap_cfg_pkg::OFS_RATIO, 32'hFFFF_FFFF);
        rd(strap_cfg_pkg::OFS_RATIO);
        `CHK(d, {11'h0, 5'h09, 4'h0, 4'h3, 3'h0, 5'h09}, "ratio read-only")
        // block disable against arbiter strap; platform 400, memory 200, core 800
        for (int a = 0; a < 2; a++) begin
            do_reset(4'h8, 3'h4, 1'b0, 1'b0, a[0]);
            `CHK(O_PCI_ADDR_OE, 1'b1, "pci drive enabled")
            wr(strap_cfg_pkg::OFS_BLOCK_DISABLE, 32'hFFFF_FFFF);
            @(posedge I_CLK);
            #1 `CHK(O_PCI_ADDR_OE, a[0], "pci drive with block disabled")
            rd(strap_cfg_pkg::OFS_BLOCK_DISABLE);
            `CHK(d, 32'h1, "block disable read")
            wr(strap_cfg_pkg::OFS_BLOCK_DISABLE, 32'h0);
            @(posedge I_CLK);
            #1 `CHK(O_PCI_ADDR_OE, 1'b1, "pci drive re-enabled")
        end
        close_out();
    end
endmodule
`default_nettype wire

// >>> dv/strap_board.sv
`timescale 1ns/10ps
`default_nettype none
module strap_board (
    // board settings
    input wire logic [3:0] i_bus,
    input wire logic [2:0] i_core,
    input wire logic i_srds_drv,
    input wire logic i_srds_val,
    input wire logic i_arb,
    input wire logic i_wiggle,
    // strap pins
    output logic [3:0] o_bus,
    output logic [2:0] o_core,
    output logic o_srds,
    output logic o_arb,
    output logic [3:0] o_spare
);
    // ratio straps always driven; pins reused for other traffic after reset
    assign o_bus = i_wiggle ? ~i_bus : i_bus;
    assign o_core = i_wiggle ? ~i_core : i_core;
    // undriven serdes select falls to its low default
    assign o_srds = i_srds_drv ? i_srds_val : 1'b0;
    assign o_arb = i_arb ^ i_wiggle;
    // spare straps low, driven high once the pins move
    assign o_spare = {4{i_wiggle}};
endmodule
`default_nettype wire

// >>> dv/strap_cfg_chk_props.sv
`timescale 1ns/10ps
`default_nettype none
module strap_cfg_chk (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // watched outputs
    input wire logic O_CFG_PULLUP_EN,
    input wire logic O_SRDS_PULLUP_EN,
    input wire logic [4:0] O_PLAT_MULT,
    input wire logic O_PLAT_RATIO_OK,
    input wire logic [3:0] O_CORE_HALVES,
    input wire logic O_CORE_RATIO_OK,
    input wire logic [4:0] O_MEM_HALVES,
    input wire logic O_SRDS_REFCLK_SEL,
    input wire logic O_CFG_DONE
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    // edges since reset release, saturating
    always_comb begin
        cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
    end
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    chk_early_idle: assert property (cnt_r < 3'h4 |-> !O_CFG_DONE)
        else $error("done raised before capture");
    chk_done_time: assert property (cnt_r == 3'h4 |-> O_CFG_DONE)
        else $error("done late after reset release");
    chk_pullup_gate: assert property (O_CFG_PULLUP_EN == !O_CFG_DONE)
        else $error("pull-up enable not tied to capture");
    chk_srds_nopull: assert property (!O_SRDS_PULLUP_EN)
        else $error("serdes strap pull-up enabled");
    chk_ratio_hold: assert property (O_CFG_DONE && $past(O_CFG_DONE) |->
        $stable({O_PLAT_MULT, O_CORE_HALVES, O_SRDS_REFCLK_SEL}))
        else $error("captured ratios changed");
    chk_mem_half: assert property (O_CFG_DONE |-> O_MEM_HALVES == O_PLAT_MULT)
        else $error("memory clock ratio wrong");
    chk_plat_valid: assert property (O_CFG_DONE |->
        O_PLAT_RATIO_OK == (O_PLAT_MULT != 5'h00))
        else $error("platform ok flag wrong");
    chk_core_valid: assert property (O_CFG_DONE |->
        O_CORE_RATIO_OK == (O_CORE_HALVES != 4'h0))
        else $error("core ok flag wrong");
    cover property ($rose(O_CFG_DONE));
    cover property (O_CFG_DONE && !O_PLAT_RATIO_OK);
    cover property (O_CFG_DONE && !O_CORE_RATIO_OK);
endmodule
bind reset_strap_clock_ratio_config strap_cfg_chk i_chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .O_CFG_PULLUP_EN(O_CFG_PULLUP_EN), .O_SRDS_PULLUP_EN(O_SRDS_PULLUP_EN),
    .O_PLAT_MULT(O_PLAT_MULT), .O_PLAT_RATIO_OK(O_PLAT_RATIO_OK),
    .O_CORE_HALVES(O_CORE_HALVES), .O_CORE_RATIO_OK(O_CORE_RATIO_OK),
    .O_MEM_HALVES(O_MEM_HALVES), .O_SRDS_REFCLK_SEL(O_SRDS_REFCLK_SEL),
    .O_CFG_DONE(O_CFG_DONE));
`default_nettype wire

// >>> pkg/strap_cap_if.sv
`timescale 1ns/10ps
`default_nettype none
interface strap_cap_if;
    logic [3:0] bus_code;
    logic [2:0] core_code;
    logic srds_sel;
    logic pci_arb_int;
    logic [3:0] spare;
    logic done;

    modport cap (
        output bus_code,
        output core_code,
        output srds_sel,
        output pci_arb_int,
        output spare,
        output done
    );

    modport use_side (
        input bus_code,
        input core_code,
        input srds_sel,
        input pci_arb_int,
        input spare,
        input done
    );
endinterface
`default_nettype wire

// >>> pkg/strap_cfg_pkg.sv
`default_nettype none
package strap_cfg_pkg;

    // register map, word offsets on the plain register port
    localparam logic [3:0] OFS_STRAP_RAW = 4'h0;
    localparam logic [3:0] OFS_RATIO = 4'h1;
    localparam logic [3:0] OFS_BLOCK_DISABLE = 4'h2;
    localparam logic [3:0] OFS_CFG_STATUS = 4'h3;

    // raw strap register fields
    localparam int RAW_BUS_POS = 0;
    localparam int RAW_CORE_POS = 4;
    localparam int RAW_SRDS_POS = 7;
    localparam int RAW_ARB_POS = 8;
    localparam int RAW_SPARE_POS = 9;

    // ratio register fields
    localparam int RATIO_BUS_POS = 0;
    localparam int RATIO_CORE_POS = 8;
    localparam int RATIO_MEM_POS = 16;

    // block disable register fields
    localparam int BDIS_PCI_POS = 0;

    // status register fields
    localparam int STAT_DONE_POS = 0;
    localparam int STAT_BUS_OK_POS = 1;
    localparam int STAT_CORE_OK_POS = 2;

    // values after reset
    localparam logic [31:0] BLOCK_DISABLE_RST = 32'h0000_0000;
    localparam logic [3:0] BUS_CODE_RST = 4'h0;
    localparam logic [2:0] CORE_CODE_RST = 3'h0;
    localparam logic [3:0] SPARE_RST = 4'h0;

    // cycles after reset release before the synchronised straps are taken
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    typedef struct packed {
        logic [4:0] mult;
        logic ok;
    } bus_ratio_type;

    typedef struct packed {
        logic [3:0] halves;
        logic ok;
    } core_ratio_type;

    // platform clock to reference clock multiplier
    function automatic bus_ratio_type decode_bus(input logic [3:0] code);
        bus_ratio_type r;
        r = '{mult: 5'h00, ok: 1'b1};
        unique case (code)
            4'h0: r.mult = 5'h10;
            4'h3: r.mult = 5'h03;
            4'h4: r.mult = 5'h04;
            4'h5: r.mult = 5'h05;
            4'h6: r.mult = 5'h06;
            4'h8: r.mult = 5'h08;
            4'h9: r.mult = 5'h09;
            4'hA: r.mult = 5'h0A;
            4'hC: r.mult = 5'h0C;
            default: r.ok = 1'b0;
        endcase
        return r;
    endfunction

    // core clock to platform clock ratio, in halves
    function automatic core_ratio_type decode_core(input logic [2:0] code);
        core_ratio_type r;
        r = '{halves: 4'h0, ok: 1'b1};
        unique case (code)
            3'h0: r.halves = 4'h8;
            3'h3: r.halves = 4'h3;
            3'h4: r.halves = 4'h4;
            3'h5: r.halves = 4'h5;
            3'h6: r.halves = 4'h6;
            3'h7: r.halves = 4'h7;
            default: r.ok = 1'b0;
        endcase
        return r;
    endfunction

endpackage
`default_nettype wire
